// ---- inc/ptf_pkg.sv ----
/*
  Package for the third/fourth port pin configuration block: register
  addresses, reset values and the special-function-register access carrier.
  Assumes an 8-bit special-function-register bus with one-cycle strobes.
*/
package ptf_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] PTF_ADDR_P4_OUT_MODE = 8'hAE;
  localparam logic [7:0] PTF_ADDR_P4_LATCH    = 8'hC7;
  localparam logic [7:0] PTF_ADDR_P3_IN_MODE  = 8'hF4;
  localparam logic [7:0] PTF_ADDR_P4_IN_MODE  = 8'hF5;
  localparam logic [7:0] PTF_ADDR_P3_SKIP     = 8'hDF;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PTF_RST_P4_OUT_MODE = 8'h00;
  localparam logic [7:0] PTF_RST_P4_LATCH    = 8'hFF;
  localparam logic [7:0] PTF_RST_P3_IN_MODE  = 8'hFF;
  localparam logic [7:0] PTF_RST_P4_IN_MODE  = 8'hFF;
  localparam logic [7:0] PTF_RST_P3_SKIP     = 8'h00;

  localparam int PTF_PINS = 8;

  // ****************************************
  // Bus carrier and pin control bundle
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ptf_sfr_req_t;

  typedef struct packed {
    logic       out;
    logic       oe;
    logic       pullup_en;
    logic       rx_en;
  } ptf_pin_ctl_t;

endpackage : ptf_pkg

// ---- rtl/ptf_pin_cell.sv ----
/*
  One port pin cell: output driver control and input receiver gating.
  Assumes the pin input has already passed a two-flop synchroniser.
*/
`timescale 1ns/1ps
module ptf_pin_cell
  import ptf_pkg::*;
(
  input  wire logic         latch_bit,
  input  wire logic         out_mode_bit,
  input  wire logic         in_mode_bit,
  input  wire logic         pin_sync,
  output ptf_pin_ctl_t      ctl,
  output logic              rd_bit
);

  always_comb
  begin
    ctl.out       = 1'b0;
    ctl.oe        = 1'b0;
    ctl.pullup_en = 1'b0;
    ctl.rx_en     = 1'b0;
    rd_bit        = 1'b0;
    if (in_mode_bit)
    begin
      ctl.rx_en = 1'b1;
      if (!latch_bit)
      begin
        ctl.out = 1'b0;
        ctl.oe  = 1'b1;
      end
      else if (out_mode_bit)
      begin
        ctl.out = 1'b1;
        ctl.oe  = 1'b1;
      end
      else
      begin
        // Open-drain high: released, weak pull-up holds it
        ctl.pullup_en = 1'b1;
      end
      rd_bit = pin_sync;
    end
    // Analog: driver, receiver, pull-up off; reads zero
  end

endmodule : ptf_pin_cell

// ---- rtl/ptf_port_cfg.sv ----
/*
  Third/fourth port configuration: fourth port latch, input and output
  mode registers, third port input mode and crossbar skip registers.
  Assumes one-cycle read/write strobes on the internal register bus, all
  on SYS_CLK, and that the pad turns OE/OUT into a pin level.
*/
`timescale 1ns/1ps
module ptf_port_cfg
  import ptf_pkg::*;
(
  input  wire logic         SYS_CLK,
  input  wire logic         RST_N,
  input  ptf_pkg::ptf_sfr_req_t SFR_REQ,
  output logic [7:0]        SFR_RDATA,
  output logic              SFR_HIT,
  input  wire logic [7:0]   P4_PIN_I,
  output logic [7:0]        P4_PIN_O,
  output logic [7:0]        P4_PIN_OE,
  output logic [7:0]        P4_PULLUP_EN,
  output logic [7:0]        P4_RX_EN,
  output logic [7:0]        P3_ANALOG_N,
  output logic [7:0]        P3_SKIP
);

  import ptf_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] p4_latch_r,    p4_latch_nxt;
  logic [7:0] p4_out_mode_r, p4_out_mode_nxt;
  logic [7:0] p4_in_mode_r,  p4_in_mode_nxt;
  logic [7:0] p3_in_mode_r,  p3_in_mode_nxt;
  logic [7:0] p3_skip_r,     p3_skip_nxt;
  logic [7:0] rdata_r,       rdata_nxt;
  logic [7:0] sync1_r,       sync2_r;
  logic [7:0] p4_rd;

  always_comb
  begin
    p4_latch_nxt    = p4_latch_r;
    p4_out_mode_nxt = p4_out_mode_r;
    p4_in_mode_nxt  = p4_in_mode_r;
    p3_in_mode_nxt  = p3_in_mode_r;
    p3_skip_nxt     = p3_skip_r;
    if (SFR_REQ.wr)
    begin
      case (SFR_REQ.addr)
        PTF_ADDR_P4_LATCH:    p4_latch_nxt    = SFR_REQ.wdata;
        PTF_ADDR_P4_OUT_MODE: p4_out_mode_nxt = SFR_REQ.wdata;
        PTF_ADDR_P4_IN_MODE:  p4_in_mode_nxt  = SFR_REQ.wdata;
        PTF_ADDR_P3_IN_MODE:  p3_in_mode_nxt  = SFR_REQ.wdata;
        PTF_ADDR_P3_SKIP:     p3_skip_nxt     = SFR_REQ.wdata;
        default:              p4_latch_nxt    = p4_latch_r;
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (SFR_REQ.rd)
    begin
      case (SFR_REQ.addr)
        PTF_ADDR_P4_LATCH:    rdata_nxt = p4_rd;
        PTF_ADDR_P4_OUT_MODE: rdata_nxt = p4_out_mode_r;
        PTF_ADDR_P4_IN_MODE:  rdata_nxt = p4_in_mode_r;
        PTF_ADDR_P3_IN_MODE:  rdata_nxt = p3_in_mode_r;
        PTF_ADDR_P3_SKIP:     rdata_nxt = p3_skip_r;
        default:              rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    case (SFR_REQ.addr)
      PTF_ADDR_P4_LATCH,
      PTF_ADDR_P4_OUT_MODE,
      PTF_ADDR_P4_IN_MODE,
      PTF_ADDR_P3_IN_MODE,
      PTF_ADDR_P3_SKIP:     SFR_HIT = SFR_REQ.rd | SFR_REQ.wr;
      default:              SFR_HIT = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      p4_latch_r    <= PTF_RST_P4_LATCH;
      p4_out_mode_r <= PTF_RST_P4_OUT_MODE;
      p4_in_mode_r  <= PTF_RST_P4_IN_MODE;
      p3_in_mode_r  <= PTF_RST_P3_IN_MODE;
      p3_skip_r     <= PTF_RST_P3_SKIP;
      rdata_r       <= 8'h00;
      sync1_r       <= 8'h00;
      sync2_r       <= 8'h00;
    end
    else
    begin
      p4_latch_r    <= p4_latch_nxt;
      p4_out_mode_r <= p4_out_mode_nxt;
      p4_in_mode_r  <= p4_in_mode_nxt;
      p3_in_mode_r  <= p3_in_mode_nxt;
      p3_skip_r     <= p3_skip_nxt;
      rdata_r       <= rdata_nxt;
      sync1_r       <= P4_PIN_I;
      sync2_r       <= sync1_r;
    end
  end

  // ****************************************
  // Pin cells
  // ****************************************
  generate
    for (genvar i = 0; i < PTF_PINS; i++)
    begin : g_pin
      ptf_pin_ctl_t ctl;
      ptf_pin_cell u_cell
      (
        .latch_bit    (p4_latch_r[i]),
        .out_mode_bit (p4_out_mode_r[i]),
        .in_mode_bit  (p4_in_mode_r[i]),
        .pin_sync     (sync2_r[i]),
        .ctl          (ctl),
        .rd_bit       (p4_rd[i])
      );
      assign P4_PIN_O[i]     = ctl.out;
      assign P4_PIN_OE[i]    = ctl.oe;
      assign P4_PULLUP_EN[i] = ctl.pullup_en;
      assign P4_RX_EN[i]     = ctl.rx_en;
    end
  endgenerate

  assign SFR_RDATA   = rdata_r;
  assign P3_ANALOG_N = p3_in_mode_r;
  assign P3_SKIP     = p3_skip_r;

endmodule : ptf_port_cfg

// ---- sim/port_three_four_pin_config_bench.sv ----
/* Bench for the port config block.
   Assumes the pin model in ptf_pads. */
`timescale 1ns/1ps
module port_three_four_pin_config_bench;
  import ptf_pkg::*;
  logic clk = 0, rst_n = 0;
  ptf_sfr_req_t req = '0;
  logic [7:0] rd_d, o, oe, pu, rx, p3a, p3s, pin, ext_o = 0, ext_oe = 0;
  logic hit, hit_s;
  int fail_count = 0, check_count = 0;
  ptf_port_cfg i_dut (.SYS_CLK(clk), .RST_N(rst_n), .SFR_REQ(req),
    .SFR_RDATA(rd_d), .SFR_HIT(hit), .P4_PIN_I(pin), .P4_PIN_O(o),
    .P4_PIN_OE(oe), .P4_PULLUP_EN(pu), .P4_RX_EN(rx),
    .P3_ANALOG_N(p3a), .P3_SKIP(p3s));
  ptf_pads i_pads (.clk_i({8{clk}}), .drv_o(o), .drv_oe(oe), .pull_en(pu),
    .ext_o(ext_o), .ext_oe(ext_oe), .pin(pin));
  initial forever #4 clk = ~clk;
  task chk(string n, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    req.wr = 1; req.addr = a; req.wdata = d;
    @(posedge clk) #1 req.wr = 0;
    repeat (3) @(posedge clk);
    #1;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e);
    req.rd = 1; req.addr = a;
    #1 hit_s = hit;
    @(posedge clk) #1 req.rd = 0;
    chk("read", rd_d, e);
    // Only address 00 is unmapped in these tests
    chk("hit", {7'h00, hit_s}, {7'h00, a != 8'h00});
    // Let an edge pass so a following request never meets this release
    @(posedge clk) #1;
  endtask : rd
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    repeat (2) @(posedge clk);
    #1;
    rd(8'hAE, 8'h00); rd(8'hC7, 8'hFF); rd(8'hF4, 8'hFF); rd(8'hF5, 8'hFF);
    rd(8'hDF, 8'h00); chk("oe", oe, 8'h00); chk("pu", pu, 8'hFF);
    $display("reset test done");
    wr(8'hF4, 8'h3C); wr(8'hDF, 8'hC3); rd(8'h00, 8'h00);
    chk("p3a", p3a, 8'h3C); chk("p3s", p3s, 8'hC3);
    $display("third port test done");
    wr(8'hC7, 8'hA5); chk("oe", oe, 8'h5A);
    chk("low", o & oe, 8'h00); rd(8'hC7, 8'hA5);
    wr(8'hAE, 8'hF0); chk("oe", oe, 8'hFA); rd(8'hC7, 8'hA5);
    $display("drive test done");
    wr(8'hC7, 8'hFF); wr(8'hAE, 8'h00); ext_o = 8'h3C; ext_oe = 8'hFF;
    repeat (3) @(posedge clk);
    #1 rd(8'hC7, 8'h3C);
    wr(8'hF5, 8'h0F); rd(8'hC7, 8'h0C); chk("rx", rx, 8'h0F);
    ext_oe = 8'h00; wr(8'hAE, 8'hFF); chk("oe", oe, 8'h0F);
    chk("pu", pu, 8'h00); rd(8'hC7, 8'h0F);
    $display("input mode test done");
    complete_run();
  end
endmodule : port_three_four_pin_config_bench

// ---- sim/ptf_pads.sv ----
/* Package pins of the fourth port.
   Assumes one outside driver per pin. */
`timescale 1ns/1ps
module ptf_pads
  import ptf_pkg::*;
(
  input wire logic [7:0]  clk_i,
  input wire logic [7:0]  drv_o,
  input wire logic [7:0]  drv_oe,
  input wire logic [7:0]  pull_en,
  input wire logic [7:0]  ext_o,
  input wire logic [7:0]  ext_oe,
  output logic [7:0]      pin
);
  logic [7:0] flt_r = 8'h55;
  always @(posedge clk_i[0]) flt_r <= ~flt_r;
  // Floating pin wanders each cycle
  always_comb
  begin
    pin = (ext_oe & ext_o) | (~ext_oe & drv_oe & drv_o) |
      (~ext_oe & ~drv_oe & (pull_en | flt_r));
  end
endmodule : ptf_pads

// ---- sim/ptf_props.sv ----
/* Checker for the port config block.
   Bound to ptf_port_cfg. */
`timescale 1ns/1ps
module ptf_props
  import ptf_pkg::*;
(
  input wire logic             SYS_CLK,
  input wire logic             RST_N,
  input ptf_pkg::ptf_sfr_req_t SFR_REQ,
  input wire logic [7:0]       SFR_RDATA,
  input wire logic             SFR_HIT,
  input wire logic [7:0]       P4_PIN_I,
  input wire logic [7:0]       P4_PIN_O,
  input wire logic [7:0]       P4_PIN_OE,
  input wire logic [7:0]       P4_PULLUP_EN,
  input wire logic [7:0]       P4_RX_EN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire rdl = SFR_REQ.rd && SFR_REQ.addr == PTF_ADDR_P4_LATCH;
  wire wrl = SFR_REQ.wr && SFR_REQ.addr == PTF_ADDR_P4_LATCH;
  latch_low_a: assert property (wrl |=> (P4_PIN_OE & ~P4_PIN_O) ==
    (~$past(SFR_REQ.wdata) & P4_RX_EN)) else $error("latch drive");
  od_release_a: assert property ((P4_PULLUP_EN & P4_PIN_OE) == 8'h00)
    else $error("pull-up while driving");
  analog_off_a: assert property (((P4_PIN_OE | P4_PULLUP_EN) & ~P4_RX_EN)
    == 8'h00) else $error("analog pin active");
  analog_read_a: assert property (rdl |=> (SFR_RDATA & ~$past(P4_RX_EN))
    == 8'h00) else $error("analog bit read");
  live_read_a: assert property (rdl && $stable(P4_PIN_I) &&
    $past(P4_PIN_I) == $past(P4_PIN_I, 2) |=> SFR_RDATA ==
    ($past(P4_PIN_I) & $past(P4_RX_EN))) else $error("pin read");
  unmapped_rd_a: assert property (SFR_REQ.rd && SFR_REQ.addr == 8'h00 |->
    !SFR_HIT ##1 SFR_RDATA == 8'h00) else $error("unmapped read");
  hold_data_a: assert property (!SFR_REQ.rd |=> $stable(SFR_RDATA))
    else $error("read data moved");
endmodule : ptf_props
bind ptf_port_cfg ptf_props i_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
  .P4_PIN_I(P4_PIN_I), .P4_PIN_O(P4_PIN_O), .P4_PIN_OE(P4_PIN_OE),
  .P4_PULLUP_EN(P4_PULLUP_EN), .P4_RX_EN(P4_RX_EN));
